// File: rtl/scorr_pkg.sv
// constants, types and helpers shared by the offset-correction block
// assumes one clock and a synchronous active-low reset in every user
`default_nettype none
package scorr_pkg;
    localparam int DW = 24;
    localparam int AW = 4;
    localparam logic [AW-1:0] ADDR_OFFSET = 4'h0;
    localparam logic [AW-1:0] ADDR_CTRL = 4'h1;
    localparam logic [AW-1:0] ADDR_STATUS = 4'h2;
    localparam int CTRL_W = 3;
    localparam int CTRL_OFF_BYP = 0;
    localparam int CTRL_GAIN_BYP = 1;
    localparam int CTRL_UNIPOLAR = 2;
    localparam int CTRL_CAL_START = 3;
    localparam int STAT_CAL_BUSY = 0;
    localparam logic [DW-1:0] OFFSET_RESET = 24'h000000;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h0;
    localparam int GAIN_SHIFT = 22;
    localparam int WIDE = 50;
    localparam logic signed [DW-1:0] SAT_MAX = 24'sh7fffff;
    localparam logic signed [DW-1:0] SAT_MIN = -24'sh800000;
    localparam int PIPE_DEPTH = 3;

    typedef enum logic [0:0] {SCORR_IDLE, SCORR_MEASURE} scorr_cal_t;

    // clamp a wide signed value into the 24-bit two's complement range
    function automatic logic signed [DW-1:0] scorr_sat(input logic signed [WIDE-1:0] v);
        if (v > WIDE'(SAT_MAX)) begin
            return SAT_MAX;
        end else if (v < WIDE'(SAT_MIN)) begin
            return SAT_MIN;
        end
        return v[DW-1:0];
    endfunction
endpackage
`default_nettype wire

// File: rtl/scorr_dp_if.sv
// signals between the register bank and the correction datapath
// assumes both ends run on the same clock
`default_nettype none
interface scorr_dp_if;
    import scorr_pkg::*;
    logic ce;
    logic in_valid;
    logic signed [DW-1:0] raw;
    logic signed [DW-1:0] offset;
    logic signed [DW-1:0] gain;
    logic off_byp;
    logic gain_byp;
    logic unipolar;
    logic out_valid;
    logic signed [DW-1:0] result;
    modport core (input ce, in_valid, raw, offset, gain, off_byp, gain_byp, unipolar,
                  output out_valid, result);
    modport ctl (output ce, in_valid, raw, offset, gain, off_byp, gain_byp, unipolar,
                 input out_valid, result);
endinterface
`default_nettype wire

// File: rtl/scorr_datapath.sv
// three-stage correction chain: offset subtract, unipolar doubling, gain scale
// assumes the controls stay steady while a conversion is in flight
`default_nettype none
module scorr_datapath
    import scorr_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    scorr_dp_if.core dp
);
    logic signed [DW-1:0] diff;
    logic signed [DW-1:0] scaled;
    logic [1:0] stage_valid;
    logic signed [2*DW-1:0] product;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    assign product = scaled * dp.gain;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            stage_valid <= 2'h0;
            dp.out_valid <= 1'b0;
        end else if (dp.ce) begin
            stage_valid <= {stage_valid[0], dp.in_valid};
            dp.out_valid <= stage_valid[1];
        end
    end

    // offset comes off first, ahead of every other correction
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            diff <= '0;
        end else if (dp.ce && dp.in_valid) begin
            diff <= dp.off_byp ? dp.raw
                    : scorr_sat(WIDE'(dp.raw) - WIDE'(dp.offset));
        end
    end

    // doubling only sees the offset-corrected value
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            scaled <= '0;
        end else if (dp.ce && stage_valid[0]) begin
            scaled <= dp.unipolar ? scorr_sat(WIDE'(diff) * 2) : diff;
        end
    end

    // gain is fixed point with 1.0 at 2^22, so it reaches up to 2x
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            dp.result <= '0;
        end else if (dp.ce && stage_valid[1]) begin
            dp.result <= dp.gain_byp ? scaled
                         : scorr_sat(WIDE'(product >>> GAIN_SHIFT));
        end
    end

    offset_sub_a: assert property (dp.ce && dp.in_valid && !dp.off_byp |=>
        diff == scorr_sat(WIDE'($past(dp.raw)) - WIDE'($past(dp.offset))))
        else $error("offset not subtracted");
    offset_skip_a: assert property (dp.ce && dp.in_valid && dp.off_byp |=>
        diff == $past(dp.raw))
        else $error("bypassed offset altered the sample");
    unipolar_double_a: assert property (dp.ce && stage_valid[0] && dp.unipolar |=>
        scaled == scorr_sat(WIDE'($past(diff)) * 2))
        else $error("unipolar doubling wrong");
    gain_order_a: assert property (dp.ce && stage_valid[1] && dp.gain_byp |=>
        dp.result == $past(scaled))
        else $error("gain stage did not take the corrected value");
    pipe_latency_a: assert property (dp.ce && dp.in_valid ##1 dp.ce ##1 dp.ce |=>
        dp.out_valid)
        else $error("result not valid three cycles on");
endmodule
`default_nettype wire

// File: rtl/scorr_top.sv
// self-calibration offset register, control bits, calibration capture and serial access
// assumes the serial framer, conversion source and gain register share this clock
//
// Chosen here: the plain strobed port and the address map.
`default_nettype none
// Overview of operation
// - a 24-bit offset register that software can read and write
// - serial transfer of the offset shifts most significant bit first
// - the offset is held and used as a signed two's complement number
// - a host write stays until rewritten or replaced by self-calibration
// - subtract the offset from every result unless the bypass bit is set
// - offset comes off before self-cal gain and before system corrections
// - in unipolar mode the offset comes off before the doubling
// - unless bypassed, scale the offset-corrected result by the self-cal gain
module scorr_top
    import scorr_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [AW-1:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [31:0] rdata,
    input wire logic ser_load,
    input wire logic ser_shift,
    input wire logic ser_din,
    input wire logic ser_commit,
    output logic ser_dout,
    input wire logic conv_valid,
    input wire logic [DW-1:0] conv_raw,
    input wire logic [DW-1:0] cal_gain,
    output logic result_valid,
    output logic [DW-1:0] result,
    output logic cal_busy
);
    logic signed [DW-1:0] self_cal_offset_reg;
    logic [CTRL_W-1:0] calibration_control_reg;
    logic [DW-1:0] shifter;
    scorr_cal_t cal_state;
    logic host_wr_offset;
    logic cal_load;
    logic [31:0] next_rdata;

    scorr_dp_if dp ();

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    assign host_wr_offset = wr_stb && addr == ADDR_OFFSET;
    assign cal_load = cal_state == SCORR_MEASURE && conv_valid;

    // calibration takes the next conversion, run with the input shorted, as the offset
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cal_state <= SCORR_IDLE;
        end else if (ce) begin
            case (cal_state)
                SCORR_IDLE: begin
                    if (wr_stb && addr == ADDR_CTRL && wdata[CTRL_CAL_START]) begin
                        cal_state <= SCORR_MEASURE;
                    end
                end
                SCORR_MEASURE: begin
                    if (conv_valid) begin
                        cal_state <= SCORR_IDLE;
                    end
                end
                default: begin
                    cal_state <= SCORR_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cal_busy <= 1'b0;
        end else if (ce) begin
            cal_busy <= (cal_state == SCORR_IDLE) ? (wr_stb && addr == ADDR_CTRL
                        && wdata[CTRL_CAL_START]) : !conv_valid;
        end
    end

    // calibration result beats a same-cycle host write; bus beats serial commit
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            self_cal_offset_reg <= OFFSET_RESET;
        end else if (ce) begin
            if (cal_load) begin
                self_cal_offset_reg <= conv_raw; // all 24 bits at once
            end else if (host_wr_offset) begin
                self_cal_offset_reg <= wdata[DW-1:0];
            end else if (ser_commit) begin
                self_cal_offset_reg <= shifter;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            calibration_control_reg <= CTRL_RESET;
        end else if (ce && wr_stb && addr == ADDR_CTRL) begin
            calibration_control_reg <= wdata[CTRL_W-1:0];
        end
    end

    // load takes a whole snapshot, so a shift-out never mixes old and new
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            shifter <= '0;
        end else if (ce) begin
            if (ser_load) begin
                shifter <= self_cal_offset_reg;
            end else if (ser_shift) begin
                shifter <= {shifter[DW-2:0], ser_din}; // msb leaves first
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ser_dout <= 1'b0;
        end else if (ce) begin
            if (ser_load) begin
                ser_dout <= self_cal_offset_reg[DW-1];
            end else if (ser_shift) begin
                ser_dout <= shifter[DW-2];
            end
        end
    end

    always_comb begin
        next_rdata = 32'h0000_0000;
        case (addr)
            ADDR_OFFSET: next_rdata = {8'h00, self_cal_offset_reg};
            ADDR_CTRL: next_rdata = {29'h0, calibration_control_reg};
            ADDR_STATUS: next_rdata = {31'h0, cal_busy};
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rdata <= 32'h0000_0000;
        end else if (ce) begin
            rdata <= rd_stb ? next_rdata : 32'h0000_0000;
        end
    end

    assign dp.ce = ce;
    assign dp.in_valid = conv_valid;
    assign dp.raw = conv_raw;
    assign dp.offset = self_cal_offset_reg;
    assign dp.gain = cal_gain;
    assign dp.off_byp = calibration_control_reg[CTRL_OFF_BYP];
    assign dp.gain_byp = calibration_control_reg[CTRL_GAIN_BYP];
    assign dp.unipolar = calibration_control_reg[CTRL_UNIPOLAR];
    assign result_valid = dp.out_valid;
    assign result = dp.result;

    scorr_datapath u_datapath (
        .clock(clock),
        .rst_n(rst_n),
        .dp(dp)
    );

    host_write_a: assert property (ce && host_wr_offset && !cal_load |=>
        self_cal_offset_reg == $past(wdata[DW-1:0]))
        else $error("host write not stored");
    offset_hold_a: assert property (ce && !host_wr_offset && !cal_load && !ser_commit |=>
        $stable(self_cal_offset_reg))
        else $error("offset changed with no writer");
    cal_atomic_a: assert property (ce && cal_load |=>
        self_cal_offset_reg == $past(conv_raw) && cal_state == SCORR_IDLE)
        else $error("calibration load not whole");
    offset_read_a: assert property (ce && rd_stb && addr == ADDR_OFFSET |=>
        rdata == {8'h00, $past(self_cal_offset_reg)})
        else $error("offset readback wrong");
    msb_first_a: assert property (ce && ser_load ##1 ce && ser_shift && !ser_load |=>
        ser_dout == $past(self_cal_offset_reg[DW-2], 2))
        else $error("serial order not msb first");

    // shift register and serial commit
    snapshot_a: assert property (ce && ser_load |=>
        shifter == $past(self_cal_offset_reg) && ser_dout == $past(self_cal_offset_reg[DW-1]))
        else $error("serial snapshot not whole");
    shift_in_a: assert property (ce && ser_shift && !ser_load |=>
        shifter == {$past(shifter[DW-2:0]), $past(ser_din)})
        else $error("serial shift-in wrong");
    dout_shift_a: assert property (ce && ser_shift && !ser_load |=>
        ser_dout == $past(shifter[DW-2]))
        else $error("serial output not next bit");
    commit_store_a: assert property (ce && ser_commit && !host_wr_offset && !cal_load |=>
        self_cal_offset_reg == $past(shifter))
        else $error("serial commit not stored");

    // register bus readback and control decode
    rdata_idle_a: assert property (ce && !rd_stb |=> rdata == 32'h0000_0000)
        else $error("read data not cleared");
    unmapped_read_a: assert property (ce && rd_stb && addr > ADDR_STATUS |=>
        rdata == 32'h0000_0000)
        else $error("unmapped address read nonzero");
    ctrl_write_a: assert property (ce && wr_stb && addr == ADDR_CTRL |=>
        calibration_control_reg == $past(wdata[CTRL_W-1:0]))
        else $error("control write not stored");
    ctrl_read_a: assert property (ce && rd_stb && addr == ADDR_CTRL |=>
        rdata == {29'h0, $past(calibration_control_reg)})
        else $error("control readback wrong");
    status_read_a: assert property (ce && rd_stb && addr == ADDR_STATUS |=>
        rdata == {31'h0, $past(cal_busy)})
        else $error("status readback wrong");

    // calibration wait and clock-enable freeze
    cal_wait_a: assert property (ce && cal_state == SCORR_MEASURE && !conv_valid |=>
        cal_busy && cal_state == SCORR_MEASURE)
        else $error("calibration wait dropped early");
    ce_freeze_a: assert property (!ce |=>
        $stable(self_cal_offset_reg) && $stable(rdata) && $stable(calibration_control_reg))
        else $error("state moved with clock enable low");
endmodule
`default_nettype wire

// File: tb/scorr_host_model.sv
// host side of the serial register port: frames the offset word both ways
// assumes the block's clock; pulses are launched right after rising edges
`default_nettype none
module scorr_host_model
    import scorr_pkg::*;
(
    input wire logic clock,
    input wire logic ser_dout,
    output logic ser_load,
    output logic ser_shift,
    output logic ser_din,
    output logic ser_commit
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        ser_load = 1'b0;
        ser_shift = 1'b0;
        ser_din = 1'b0;
        ser_commit = 1'b0;
    end

    task automatic send_word(input logic [DW-1:0] v);
        for (int i = DW - 1; i >= 0; i--) begin
            @(posedge clock);
            ser_shift <= 1'b1;
            ser_din <= v[i];
        end
        @(posedge clock);
        ser_shift <= 1'b0;
        ser_commit <= 1'b1;
        // idle line shows the inverse, so a stale bit cannot pass for data
        ser_din <= ~v[0];
        @(posedge clock);
        ser_commit <= 1'b0;
    endtask

    task automatic fetch_word(output logic [DW-1:0] v);
        @(posedge clock);
        ser_load <= 1'b1;
        @(posedge clock);
        ser_load <= 1'b0;
        ser_shift <= 1'b1;
        for (int i = DW - 1; i >= 0; i--) begin
            @(negedge clock);
            v[i] = ser_dout;
            @(posedge clock);
            ser_shift <= (i > 1);
        end
    endtask
endmodule
`default_nettype wire

// File: tb/self_cal_offset_correction_tb.sv
// self-checking bench: register bus, serial port, correction chain, calibration
// assumes the host model drives the serial pins; ce is high except in the freeze scenario
`default_nettype none
module self_cal_offset_correction_tb import scorr_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic [AW-1:0] addr = '0;
    logic [31:0] wdata = '0;
    logic wr_stb = 1'b0;
    logic rd_stb = 1'b0;
    logic conv_valid = 1'b0;
    logic [DW-1:0] conv_raw = '0;
    logic [DW-1:0] cal_gain = 24'h400000;
    logic [31:0] rdata;
    logic ser_load, ser_shift, ser_din, ser_commit, ser_dout;
    logic result_valid, cal_busy;
    logic [DW-1:0] result;
    logic [DW-1:0] sv;
    logic [31:0] rv;
    int n_errors = 0;
    int samples_checked = 0;

    always #25 clock = ~clock;

    scorr_top uut (.clock(clock), .rst_n(rst_n), .ce(ce), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .ser_load(ser_load),
        .ser_shift(ser_shift), .ser_din(ser_din), .ser_commit(ser_commit),
        .ser_dout(ser_dout), .conv_valid(conv_valid), .conv_raw(conv_raw),
        .cal_gain(cal_gain), .result_valid(result_valid), .result(result),
        .cal_busy(cal_busy));
    scorr_host_model host (.clock(clock), .ser_dout(ser_dout), .ser_load(ser_load),
        .ser_shift(ser_shift), .ser_din(ser_din), .ser_commit(ser_commit));

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_verdict();
        $display("checked %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge clock);
        wr_stb <= 1'b0;
    endtask
    task automatic rd(input logic [AW-1:0] a, output logic [31:0] d);
        @(posedge clock);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clock);
        rd_stb <= 1'b0;
        @(negedge clock);
        d = rdata;
    endtask
    task automatic conv(input logic [DW-1:0] raw, input logic [DW-1:0] exp);
        int n;
        @(posedge clock);
        conv_valid <= 1'b1;
        conv_raw <= raw;
        @(posedge clock);
        conv_valid <= 1'b0;
        // n counts cycles after the edge that took the sample
        n = 1;
        @(negedge clock);
        while (result_valid !== 1'b1 && n < 8) begin
            n++;
            @(negedge clock);
        end
        chk("latency", n, PIPE_DEPTH);
        if (result_valid !== 1'b1) begin
            give_verdict();
        end
        chk("result", result, exp);
        @(negedge clock);
        chk("valid pulse", result_valid, 0);
    endtask

    task automatic t_reset();
        rd(ADDR_OFFSET, rv);
        chk("offset reset", rv, 32'h00000000);
        chk("busy reset", cal_busy, 0);
    endtask
    task automatic t_bus();
        wr(ADDR_OFFSET, 32'hffa5c3e1);
        rd(ADDR_OFFSET, rv);
        chk("offset rw", rv, 32'h00a5c3e1);
        @(negedge clock);
        chk("rdata idle", rdata, 32'h00000000);
        wr(4'h7, 32'h00123456);
        rd(4'hf, rv);
        chk("unmapped", rv, 32'h00000000);
        rd(ADDR_OFFSET, rv);
        chk("offset kept", rv, 32'h00a5c3e1);
    endtask
    task automatic t_serial();
        host.fetch_word(sv);
        chk("serial read", sv, 24'ha5c3e1);
        host.send_word(24'h813c7e);
        rd(ADDR_OFFSET, rv);
        chk("serial write", rv, 32'h00813c7e);
    endtask
    task automatic t_chain();
        // the last case overflows the positive end and must clamp
        logic [3:0] c [6] = '{4'h2, 4'h2, 4'h3, 4'h6, 4'h0, 4'h2};
        logic [DW-1:0] o [6] = '{24'h000100, 24'hfffff0, 24'hfffff0, 24'h000010, 24'h000100,
            24'hfffff0};
        logic [DW-1:0] r [6] = '{24'h001000, 24'h000010, 24'h000010, 24'h000100, 24'h001000,
            24'h7ffff8};
        logic [DW-1:0] e [6] = '{24'h000f00, 24'h000020, 24'h000010, 24'h0001e0, 24'h000780,
            24'h7fffff};
        cal_gain <= 24'h200000;
        for (int i = 0; i < 6; i++) begin
            wr(ADDR_OFFSET, {8'h00, o[i]});
            wr(ADDR_CTRL, {28'h0, c[i]});
            conv(r[i], e[i]);
        end
    endtask
    task automatic t_cal();
        wr(ADDR_CTRL, 32'h0000000a);
        @(negedge clock);
        chk("busy set", cal_busy, 1);
        rd(ADDR_STATUS, rv);
        chk("status busy", rv, 32'h00000001);
        @(posedge clock);
        conv_valid <= 1'b1;
        conv_raw <= 24'h000123;
        @(posedge clock);
        conv_valid <= 1'b0;
        repeat (2) @(negedge clock);
        chk("busy clear", cal_busy, 0);
        rd(ADDR_OFFSET, rv);
        chk("cal offset", rv, 32'h00000123);
        conv(24'h000200, 24'h0000dd);
    endtask
    task automatic t_freeze();
        @(posedge clock);
        ce <= 1'b0;
        wr(ADDR_OFFSET, 32'h00000055);
        @(posedge clock);
        ce <= 1'b1;
        rd(ADDR_OFFSET, rv);
        chk("offset frozen", rv, 32'h00000123);
    endtask
    task automatic t_rerun();
        // held low over several edges so every register is already at reset on release
        @(posedge clock);
        rst_n <= 1'b0;
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        rd(ADDR_OFFSET, rv);
        chk("offset rerun", rv, 32'h00000000);
        rd(ADDR_CTRL, rv);
        chk("control rerun", rv, 32'h00000000);
        chk("busy rerun", cal_busy, 0);
    endtask

    initial begin
        repeat (12) @(posedge clock);
        rst_n <= 1'b1;
        t_reset();
        t_bus();
        t_serial();
        t_chain();
        t_cal();
        t_freeze();
        t_rerun();
        give_verdict();
    end
endmodule
`default_nettype wire
